// ==== bench/cic_irq_monitor.sv ====
// Purpose: Timing checks on the interrupt control outputs
// Assumes: One clock domain; events are one-cycle pulses
// Notes: Attached to every control block instance by bind
`timescale 1ns/1ps
`default_nettype none
module cic_irq_monitor (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Core events
    input wire clk_en,
    input wire instr_boundary,
    input wire enable_irq_instr,
    input wire disable_irq_instr,
    input wire nonmaskable_return_instr,
    input wire irq_return_instr,
    input wire load_page_from_acc,
    input wire load_acc_from_page,
    input wire load_acc_from_refresh,
    input wire [7:0] acc_in,
    input wire undef_opcode,
    // Responses
    input wire ack_ff,
    input wire [2:0] ack_kind_ff,
    input wire [15:0] target_addr_ff,
    input wire vector_fetch_ff,
    input wire dma_master_enable_clr_ff,
    input wire parity_load_ff,
    input wire parity_value_ff,
    input wire [7:0] vector_page_ff,
    input wire global_irq_enable_ff,
    input wire saved_irq_enable_ff
);
    // Single domain, so clock and disable are stated once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    trap_entry_a: assert property (clk_en && undef_opcode |=> ack_ff &&
        ack_kind_ff == 3'h1 && target_addr_ff == 16'h0000 && $stable(global_irq_enable_ff))
        else $error("trap entry wrong");
    nmi_entry_a: assert property (ack_ff && ack_kind_ff == 3'h2 |->
        target_addr_ff == 16'h0066 && dma_master_enable_clr_ff && !global_irq_enable_ff &&
        saved_irq_enable_ff == $past(global_irq_enable_ff)) else $error("nmi entry wrong");
    ext_request0_entry_a: assert property (ack_ff && ack_kind_ff == 3'h3 |->
        target_addr_ff == 16'h0038 && !global_irq_enable_ff && !saved_irq_enable_ff)
        else $error("ext_request0 entry wrong");
    vector_addr_a: assert property (ack_ff && ack_kind_ff == 3'h4 |-> vector_fetch_ff &&
        target_addr_ff[15:8] == vector_page_ff && target_addr_ff[0] == 1'h0 &&
        !global_irq_enable_ff) else $error("vectored entry wrong");
    masked_ack_a: assert property (ack_ff && (ack_kind_ff == 3'h3 || ack_kind_ff == 3'h4)
        |-> $past(global_irq_enable_ff)) else $error("maskable taken while disabled");
    page_hold_a: assert property (!(clk_en && load_page_from_acc) |=>
        $stable(vector_page_ff)) else $error("page changed without load");
    page_load_a: assert property (clk_en && load_page_from_acc |=>
        vector_page_ff == $past(acc_in)) else $error("page load wrong");
    enable_set_a: assert property (clk_en && enable_irq_instr && !instr_boundary |=>
        global_irq_enable_ff && saved_irq_enable_ff) else $error("enable flags not set");
    disable_clr_a: assert property (clk_en && disable_irq_instr && !instr_boundary |=>
        !global_irq_enable_ff && !saved_irq_enable_ff) else $error("enable flags not cleared");
    nonmaskable_return_instr_restore_a: assert property (clk_en && nonmaskable_return_instr &&
        !instr_boundary |=> global_irq_enable_ff == $past(saved_irq_enable_ff))
        else $error("return did not restore");
    parity_copy_a: assert property (clk_en && (load_acc_from_page || load_acc_from_refresh)
        |=> parity_load_ff && parity_value_ff == $past(saved_irq_enable_ff) &&
        $stable(global_irq_enable_ff)) else $error("parity copy wrong");
    irq_return_instr_hold_a: assert property (clk_en && irq_return_instr && !instr_boundary &&
        !undef_opcode && !enable_irq_instr && !disable_irq_instr && !nonmaskable_return_instr
        |=> $stable(global_irq_enable_ff) && $stable(saved_irq_enable_ff))
        else $error("return changed enable flags");
endmodule // cic_irq_monitor
bind cic_irq_ctrl cic_irq_monitor u_mon (.sys_clk, .reset, .clk_en, .instr_boundary,
    .enable_irq_instr, .disable_irq_instr, .nonmaskable_return_instr, .irq_return_instr,
    .load_page_from_acc,
    .load_acc_from_page, .load_acc_from_refresh, .acc_in, .undef_opcode, .ack_ff, .ack_kind_ff,
    .target_addr_ff, .vector_fetch_ff, .dma_master_enable_clr_ff, .parity_load_ff,
    .parity_value_ff, .vector_page_ff, .global_irq_enable_ff, .saved_irq_enable_ff);
`default_nettype wire

// ==== bench/cic_src_model.sv ====
// Purpose: External request sources facing the control block
// Assumes: Request pins idle high, driven from the held request bits
// Notes: A request holds until acknowledged: nmi and input 0 by kind, inputs 1 and 2 by kind and low code
`timescale 1ns/1ps
`default_nettype none
module cic_src_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Requests from the bench: [0] nmi, [1..3] inputs 0..2
    input wire logic [3:0] set_req,
    // Block response
    input wire logic ack_ff,
    input wire logic [2:0] ack_kind_ff,
    input wire logic [4:0] target_low,
    input wire logic nonmaskable_return_instr,
    // Request pins, active low
    output logic [3:0] req_n
);
    logic [3:0] want_ff;
    logic nmi_busy_ff;
    assign req_n = ~want_ff;
    // A second nmi request is ignored until the handler returns, so the stack cannot run away
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            want_ff <= 4'h0;
            nmi_busy_ff <= 1'h0;
        end else begin
            want_ff <= (want_ff | (set_req & {3'h7, !nmi_busy_ff})) & ~{
                ack_ff && ack_kind_ff == 3'h4 && target_low == 5'h02,
                ack_ff && ack_kind_ff == 3'h4 && target_low == 5'h00,
                ack_ff && ack_kind_ff == 3'h3, ack_ff && ack_kind_ff == 3'h2};
            if (ack_ff && ack_kind_ff == 3'h2) nmi_busy_ff <= 1'h1;
            else if (nonmaskable_return_instr) nmi_busy_ff <= 1'h0;
        end
    end
endmodule // cic_src_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: Directed test of enables, priority and vector entry
// Assumes: Inputs change 1 ns after each rising edge
// Notes: Edge pin source takes the last, lowest-priority vectored slot
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic [8:0] ev = 9'h000;
    logic [3:0] set_req = 4'h0;
    logic [4:0] periph = 5'h00;
    logic pin = 1'h0;
    logic third = 1'h0, io_wr = 1'h0, io_rd = 1'h0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, acc = 8'h00;
    logic ack, vfetch, dmaclr, pload, pval, gie, sie;
    logic [2:0] kind;
    logic [15:0] target;
    logic [7:0] page, rdata;
    logic [3:0] req_n;
    integer compares = 0, miscompares = 0, i;
    always #5 sys_clk = ~sys_clk;
    // Event bits: boundary, ei, di, nonmaskable_return_instr, irq_return_instr, ld page, lda page, lda refresh, undef
    cic_irq_ctrl DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(1'h1), .nmi_req_n(req_n[0]),
        .ext_request0_n(req_n[1]), .ext_request1_n(req_n[2]), .ext_request2_n(req_n[3]),
        .periph_req(periph), .edge_input_pin(pin), .instr_boundary(ev[0]),
        .enable_irq_instr(ev[1]), .disable_irq_instr(ev[2]), .nonmaskable_return_instr(ev[3]),
        .irq_return_instr(ev[4]), .load_page_from_acc(ev[5]), .load_acc_from_page(ev[6]),
        .load_acc_from_refresh(ev[7]), .acc_in(acc), .undef_opcode(ev[8]),
        .undef_third_byte(third), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata_ff(rdata), .ack_ff(ack), .ack_kind_ff(kind),
        .target_addr_ff(target), .vector_fetch_ff(vfetch), .dma_master_enable_clr_ff(dmaclr),
        .parity_load_ff(pload), .parity_value_ff(pval), .vector_page_ff(page),
        .global_irq_enable_ff(gie), .saved_irq_enable_ff(sie));
    cic_src_model u_src (.sys_clk(sys_clk), .reset(reset), .set_req(set_req), .ack_ff(ack),
        .ack_kind_ff(kind), .target_low(target[4:0]), .nonmaskable_return_instr(ev[3]),
        .req_n(req_n));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle event pulse; responses are settled once it returns
    task pulse(input logic [8:0] m);
        @(posedge sys_clk) #1 ev = m;
        @(posedge sys_clk) #1 ev = 9'h000;
    endtask
    task io(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1 {io_wr, io_rd, io_addr, io_wdata} = {w, !w, a, d};
        @(posedge sys_clk) #1 {io_wr, io_rd} = 2'h0;
    endtask
    task req(input logic [3:0] m);
        @(posedge sys_clk) #1 set_req = m;
        @(posedge sys_clk) #1 set_req = 4'h0;
    endtask
    task complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Guard against a hang; reaching it is a failure
    initial begin
        #100000 miscompares = miscompares + 1;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 reset = 1'h0;
        io(0, 8'h34, 8'h00); chk(rdata & 8'hC7, 8'h01);
        io(0, 8'h33, 8'h00); chk(rdata & 8'hE0, 8'h00);
        chk({page, gie, sie}, 10'h000);
        // Input 0 waits for the global enable, then enters at 38H
        req(4'h2); pulse(9'h001); chk(ack, 1'h0);
        pulse(9'h002); chk({gie, sie}, 2'h3);
        pulse(9'h001); chk({ack, kind}, 4'hB);
        chk(target, 16'h0038); chk({gie, sie}, 2'h0);
        // Page comes only from the accumulator path, never the port bus
        acc = 8'hA5; pulse(9'h020); chk(page, 8'hA5);
        io(1, 8'h33, 8'h60); chk(page, 8'hA5);
        io(1, 8'h34, 8'h06);
        // All lower sources stay pending, so each ack shows the top one; input 0 is masked
        req(4'hE); periph = 5'h1F;
        for (i = 0; i < 7; i = i + 1) begin
            pulse(9'h001); chk(ack, 1'h0);
            pulse(9'h002);
            repeat (2) @(posedge sys_clk);
            #1 pulse(9'h001); chk({ack, kind, vfetch}, 5'h19);
            chk(target, {8'hA5, 3'h3, i[3:0], 1'h0});
            if (i > 1) periph[i-2] = 1'h0;
        end
        // Ordinary return leaves flags; nmi saves the global flag and clears it
        pulse(9'h002); pulse(9'h010); chk({gie, sie}, 2'h3);
        req(4'h1); repeat (2) @(posedge sys_clk);
        #1 pulse(9'h001); chk({ack, kind, dmaclr}, 5'h15);
        chk(target, 16'h0066); chk({gie, sie}, 2'h1);
        pulse(9'h040); chk({pload, pval, gie, sie}, 4'hD);
        pulse(9'h080); chk({pload, pval, gie, sie}, 4'hD);
        pulse(9'h008); chk({gie, sie}, 2'h3);
        // Trap on the third byte, then clear rules of the trap flag
        third = 1'h1; pulse(9'h100); chk({ack, kind}, 4'h9);
        chk(target, 16'h0000); chk({gie, sie}, 2'h3);
        io(0, 8'h34, 8'h00); chk(rdata[7:6], 2'h3);
        io(1, 8'h34, 8'h06); io(0, 8'h34, 8'h00); chk(rdata[7], 1'h0);
        io(1, 8'h34, 8'h86); io(0, 8'h34, 8'h00); chk(rdata[7], 1'h0);
        // Pin rise enters at code 0E; its flag clears only on a read while low
        io(1, 8'h04, 8'h08); pin = 1'h1; repeat (2) @(posedge sys_clk);
        #1 pulse(9'h001); chk({ack, kind, vfetch}, 5'h19);
        chk(target, 16'hA56E); io(0, 8'h04, 8'h00); chk(rdata, 8'h0C);
        pin = 1'h0; io(0, 8'h04, 8'h00); chk(rdata, 8'h0C);
        io(0, 8'h04, 8'h00); chk(rdata, 8'h08);
        // Bad opcode during an acknowledge still traps; second-byte position
        third = 1'h0; pulse(9'h002); req(4'h4); repeat (2) @(posedge sys_clk);
        #1 pulse(9'h101); chk({ack, kind}, 4'h9);
        io(0, 8'h34, 8'h00); chk(rdata[7:6], 2'h2);
        pulse(9'h004); chk({gie, sie}, 2'h0);
        complete_run;
    end
endmodule // tb_top
`default_nettype wire

// ==== rtl/cic_consts.vh ====
// Purpose: Constants for the processor interrupt control block
// Assumes: Included by the top design file of the block
// Notes: Offsets are I/O port addresses on the core's port bus
`ifndef CIC_CONSTS_VH
`define CIC_CONSTS_VH
`define CIC_ADDR_VECTOR_LOW 8'h33
`define CIC_ADDR_TRAP_ENABLE 8'h34
`define CIC_ADDR_PIN_STATUS 8'h04
`define CIC_TE_TRAP_BIT 7
`define CIC_TE_FETCHPOS_BIT 6
`define CIC_PIN_IRQEN_BIT 3
`define CIC_PIN_FLAG_BIT 2
`define CIC_RST_VECTOR_PAGE 8'h00
`define CIC_RST_VECTOR_LOW 3'h0
`define CIC_RST_INPUT_ENABLE 3'h1
`define CIC_ADDR_NMI 16'h0066
`define CIC_ADDR_EXT_REQUEST0 16'h0038
`define CIC_ADDR_TRAP 16'h0000
`define CIC_SRC_COUNT 8
`define CIC_CODE_PIN 5'h0E
`define CIC_KIND_NONE 3'h0
`define CIC_KIND_TRAP 3'h1
`define CIC_KIND_NMI 3'h2
`define CIC_KIND_EXT_REQUEST0 3'h3
`define CIC_KIND_VECT 3'h4
`endif

// ==== rtl/cic_edge_latch.v ====
// Purpose: Edge detector with a sticky latch, cleared by the consumer
// Assumes: Input is synchronous to sys_clk
// Notes: A new edge in the clear cycle keeps the latch set
`timescale 1ns/1ps
`default_nettype none
module cic_edge_latch (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // Level in, latched edge out
    input wire level_in,
    input wire rise_mode,
    input wire clear,
    output reg latched_ff
);
    reg prev_ff;
    wire edge_seen;

    // Edge polarity selectable: falling for active-low pins
    assign edge_seen = rise_mode ? (level_in & ~prev_ff) : (~level_in & prev_ff);

    // Set wins over clear so no edge is lost
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prev_ff <= 1'b0;
            latched_ff <= 1'b0;
        end else if (clk_en) begin
            prev_ff <= level_in;
            if (edge_seen)
                latched_ff <= 1'b1;
            else if (clear)
                latched_ff <= 1'b0;
        end
    end
endmodule // cic_edge_latch
`default_nettype wire

// ==== rtl/cic_irq_ctrl.v ====
// Purpose: Interrupt control of an 8-bit core: enables, priority, vectors
// Assumes: Core signals are synchronous pulses; ext requests are active low
// Notes: Core performs the stack push and table read from the outputs
`timescale 1ns/1ps
`default_nettype none
`include "cic_consts.vh"
module cic_irq_ctrl #(
    parameter NSRC = `CIC_SRC_COUNT
) (
    // Clock, reset, enable
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // External request pins, active low
    input wire nmi_req_n,
    input wire ext_request0_n,
    input wire ext_request1_n,
    input wire ext_request2_n,
    // Internal peripheral requests, already gated by their own enables
    input wire [4:0] periph_req, // timer 0, timer 1, DMA 0, DMA 1, serial
    // Edge input pin
    input wire edge_input_pin,
    // Core instruction events, one-cycle pulses
    input wire instr_boundary,
    input wire enable_irq_instr,
    input wire disable_irq_instr,
    input wire nonmaskable_return_instr,
    input wire irq_return_instr,
    input wire load_page_from_acc,
    input wire load_acc_from_page,
    input wire load_acc_from_refresh,
    input wire [7:0] acc_in,
    input wire undef_opcode,
    input wire undef_third_byte,
    // I/O port bus from the core
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_addr,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata_ff,
    // Response to the core
    output reg ack_ff,
    output reg [2:0] ack_kind_ff,
    output reg [15:0] target_addr_ff,
    output reg vector_fetch_ff,
    output reg dma_master_enable_clr_ff,
    output reg parity_load_ff,
    output reg parity_value_ff,
    output reg [7:0] vector_page_ff,
    output reg global_irq_enable_ff,
    output reg saved_irq_enable_ff
);
    // Control state
    reg [2:0] vector_low_select_ff;
    reg [2:0] input_enable_ff; // bits 2..0: inputs 2, 1, 0
    reg trap_flag_ff;
    reg fetch_position_flag_ff;
    reg pin_irq_enable_ff;
    reg pin_flag_ff;
    reg pin_prev_ff;
    reg pin_edge_ff;
    wire nmi_pending;
    wire nmi_clear;
    wire [NSRC-1:0] vect_req;
    wire vect_any;
    wire [4:0] vect_code;
    wire pin_rise;
    wire ext_request0_live;
    wire take_trap;
    wire take_nmi;
    wire take_ext_request0;
    wire take_vect;
    wire wr_trap_enable;
    wire wr_vector_low;
    wire rd_pin_status;
    wire pin_taken;

    // Port decode; shared by read and write paths
    function is_addr;
        input [7:0] a;
        input [7:0] want;
        begin
            is_addr = (a == want);
        end
    endfunction

    assign wr_trap_enable = io_wr & is_addr(io_addr, `CIC_ADDR_TRAP_ENABLE);
    assign wr_vector_low = io_wr & is_addr(io_addr, `CIC_ADDR_VECTOR_LOW);
    assign rd_pin_status = io_rd & is_addr(io_addr, `CIC_ADDR_PIN_STATUS);
    assign pin_rise = edge_input_pin & ~pin_prev_ff;

    // Nonmaskable edge latch, cleared when accepted
    cic_edge_latch u_nmi_latch (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .level_in(nmi_req_n),
        .rise_mode(1'b0),
        .clear(nmi_clear),
        .latched_ff(nmi_pending)
    );

    // Gated vectored requests in priority order; global enable gates all
    // Lowest index ranks highest: in1, in2, timers, DMA, serial, pin
    assign vect_req = {NSRC{global_irq_enable_ff}} & {
        pin_edge_ff & pin_irq_enable_ff,
        periph_req,
        ~ext_request2_n & input_enable_ff[2],
        ~ext_request1_n & input_enable_ff[1]};

    // Registered winner; one cycle of pipeline eases timing.
    // The pipeline means a source masked by a port write can still win for one
    // cycle; clear the global flag first when masking a single source.
    // The choice is only used on an instruction boundary.
    cic_prio_enc #(
        .N(NSRC)
    ) u_prio (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .req(vect_req),
        .any_ff(vect_any),
        .code_ff(vect_code)
    );

    // Input 0 needs both global and own enable
    assign ext_request0_live = ~ext_request0_n & input_enable_ff[0] & global_irq_enable_ff;

    // Trap first regardless of enables, then NMI, EXT_REQUEST0, vectored
    assign take_trap = undef_opcode;
    assign take_nmi = ~take_trap & nmi_pending & instr_boundary;
    assign take_ext_request0 = ~take_trap & ~nmi_pending & instr_boundary & ext_request0_live;
    assign take_vect = ~take_trap & ~nmi_pending & ~ext_request0_live & instr_boundary
        & vect_any & global_irq_enable_ff;
    assign nmi_clear = take_nmi;

    // The pin request is dropped only when its own vector is taken
    assign pin_taken = take_vect & (vect_code == `CIC_CODE_PIN);

    // Response outputs, one-cycle pulses
    // Target holds until the next acknowledge, so the core may pick it up late
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack_ff <= 1'b0;
            ack_kind_ff <= `CIC_KIND_NONE;
            target_addr_ff <= 16'h0000;
            vector_fetch_ff <= 1'b0;
            dma_master_enable_clr_ff <= 1'b0;
        end else if (clk_en) begin
            ack_ff <= take_trap | take_nmi | take_ext_request0 | take_vect;
            vector_fetch_ff <= take_vect;
            dma_master_enable_clr_ff <= take_nmi;
            if (take_trap) begin
                ack_kind_ff <= `CIC_KIND_TRAP;
                target_addr_ff <= `CIC_ADDR_TRAP;
            end else if (take_nmi) begin
                ack_kind_ff <= `CIC_KIND_NMI;
                target_addr_ff <= `CIC_ADDR_NMI;
            end else if (take_ext_request0) begin
                ack_kind_ff <= `CIC_KIND_EXT_REQUEST0;
                target_addr_ff <= `CIC_ADDR_EXT_REQUEST0;
            end else if (take_vect) begin
                ack_kind_ff <= `CIC_KIND_VECT;
                target_addr_ff <= {vector_page_ff, vector_low_select_ff, vect_code};
            end else begin
                ack_kind_ff <= `CIC_KIND_NONE;
            end
        end
    end

    // Enable flags; entry events take precedence over instructions
    // An instruction event in a trap cycle is dropped; the core never issues both
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            global_irq_enable_ff <= 1'b0;
            saved_irq_enable_ff <= 1'b0;
        end else if (clk_en) begin
            if (take_trap) begin
                global_irq_enable_ff <= global_irq_enable_ff;
            end else if (take_nmi) begin
                saved_irq_enable_ff <= global_irq_enable_ff;
                global_irq_enable_ff <= 1'b0;
            end else if (take_ext_request0 | take_vect) begin
                global_irq_enable_ff <= 1'b0;
                saved_irq_enable_ff <= 1'b0;
            end else if (nonmaskable_return_instr) begin
                global_irq_enable_ff <= saved_irq_enable_ff;
            end else if (enable_irq_instr) begin
                global_irq_enable_ff <= 1'b1;
                saved_irq_enable_ff <= 1'b1;
            end else if (disable_irq_instr) begin
                global_irq_enable_ff <= 1'b0;
                saved_irq_enable_ff <= 1'b0;
            end
        end
    end

    // Parity flag load from saved enable; enables untouched
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            parity_load_ff <= 1'b0;
            parity_value_ff <= 1'b0;
        end else if (clk_en) begin
            parity_load_ff <= load_acc_from_page | load_acc_from_refresh;
            parity_value_ff <= saved_irq_enable_ff;
        end
    end

    // Vector page: only the accumulator path writes it, no port decode
    always @(posedge sys_clk or posedge reset) begin
        if (reset)
            vector_page_ff <= `CIC_RST_VECTOR_PAGE;
        else if (clk_en && load_page_from_acc)
            vector_page_ff <= acc_in;
    end

    // Port-written registers and trap flags; trap set beats clear
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            vector_low_select_ff <= `CIC_RST_VECTOR_LOW;
            input_enable_ff <= `CIC_RST_INPUT_ENABLE;
            trap_flag_ff <= 1'b0;
            fetch_position_flag_ff <= 1'b0;
            pin_irq_enable_ff <= 1'b0;
        end else if (clk_en) begin
            if (wr_vector_low)
                vector_low_select_ff <= io_wdata[7:5];
            if (wr_trap_enable)
                input_enable_ff <= io_wdata[2:0];
            if (take_trap) begin
                trap_flag_ff <= 1'b1;
                fetch_position_flag_ff <= undef_third_byte;
            end else if (wr_trap_enable && !io_wdata[`CIC_TE_TRAP_BIT]) begin
                trap_flag_ff <= 1'b0;
            end
            if (io_wr && is_addr(io_addr, `CIC_ADDR_PIN_STATUS))
                pin_irq_enable_ff <= io_wdata[`CIC_PIN_IRQEN_BIT];
        end
    end

    // Edge pin flag: set while high, read-while-low clears
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pin_prev_ff <= 1'b0;
            pin_flag_ff <= 1'b0;
            pin_edge_ff <= 1'b0;
        end else if (clk_en) begin
            pin_prev_ff <= edge_input_pin;
            if (edge_input_pin | pin_rise)
                pin_flag_ff <= 1'b1;
            else if (rd_pin_status)
                pin_flag_ff <= 1'b0;
            // A rise while enabled is held until taken; a new rise beats the clear
            if (pin_rise & pin_irq_enable_ff)
                pin_edge_ff <= 1'b1;
            else if (pin_taken)
                pin_edge_ff <= 1'b0;
        end
    end

    // Registered read data; unmapped ports read zero
    // The pin status read returns the flag in the same cycle that clears it
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            io_rdata_ff <= 8'h00;
        end else if (clk_en) begin
            io_rdata_ff <= 8'h00;
            if (io_rd && is_addr(io_addr, `CIC_ADDR_VECTOR_LOW))
                io_rdata_ff <= {vector_low_select_ff, 5'h00};
            else if (io_rd && is_addr(io_addr, `CIC_ADDR_TRAP_ENABLE))
                io_rdata_ff <= {trap_flag_ff, fetch_position_flag_ff, 3'h0, input_enable_ff};
            else if (rd_pin_status)
                io_rdata_ff <= {4'h0, pin_irq_enable_ff, pin_flag_ff, 2'h0};
        end
    end
endmodule // cic_irq_ctrl
`default_nettype wire

// ==== rtl/cic_prio_enc.v ====
// Purpose: Fixed-priority pick among the vectored sources
// Assumes: Bit 0 is the highest priority source
// Notes: Output is registered; low code is index times two
`timescale 1ns/1ps
`default_nettype none
module cic_prio_enc #(
    parameter N = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // Requests and registered choice
    input wire [N-1:0] req,
    output reg any_ff,
    output reg [4:0] code_ff
);
    integer i;
    reg found;
    reg [4:0] nxt_code;

    // Lowest index wins
    always @* begin
        found = 1'b0;
        nxt_code = 5'h00;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                found = 1'b1;
                nxt_code = {i[3:0], 1'b0};
            end
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            any_ff <= 1'b0;
            code_ff <= 5'h00;
        end else if (clk_en) begin
            any_ff <= found;
            code_ff <= nxt_code;
        end
    end
endmodule // cic_prio_enc
`default_nettype wire
